// [common/tes_params.svh]
// register indices, field positions, codes and reset values of the tx edge shaper
// assumes inclusion by bare name from the package and the testbench
`ifndef TES_PARAMS_SVH
`define TES_PARAMS_SVH

// --------------------------------------------------------------------
// register indices (byte address = 4 * index)
// --------------------------------------------------------------------
`define TES_IDX_RES212 10'h028
`define TES_IDX_TYPE212 10'h029
`define TES_IDX_STYLE212 10'h02a
`define TES_IDX_LEN212 10'h02b
`define TES_IDX_RES424 10'h02c
`define TES_IDX_TYPE424 10'h02d
`define TES_IDX_STYLE424 10'h02e
`define TES_IDX_LEN424 10'h02f
`define TES_IDX_CTRL 10'h040
`define TES_IDX_STAT 10'h041
`define TES_LUT_REGION 3'h1

// --------------------------------------------------------------------
// fields and masks
// --------------------------------------------------------------------
`define TES_STYLE_MASK 8'h77
`define TES_LEN_MASK 8'h9f
`define TES_CTRL_MASK 8'h03
`define TES_LEN_SCALE 7
`define TES_STYLE_F 6:4
`define TES_STYLE_R 2:0
`define TES_LEN_COUNT 4:0
`define TES_CTRL_RATE 0
`define TES_CTRL_EN 1

// --------------------------------------------------------------------
// edge type codes
// --------------------------------------------------------------------
`define TES_TYPE_LIN1 4'h1
`define TES_TYPE_LIN2 4'h2
`define TES_TYPE_LIN3 4'h3
`define TES_TYPE_LUT_FIX 4'h4
`define TES_TYPE_LUT_CORR 4'h5
`define TES_TYPE_LUT_RAW 4'h6

// --------------------------------------------------------------------
// levels and reset values
// --------------------------------------------------------------------
`define TES_FULL 8'hff
`define TES_FRAC_ONE 9'h100
`define TES_FRAC_HALF 9'h080
`define TES_KNEE_STEP 9'h020
`define TES_RST_RES 8'h00
`define TES_RST_TYPE 8'h11
`define TES_RST_STYLE 8'h00
`define TES_RST_LEN 8'h00
`define TES_RST_CTRL 8'h02

`endif

// [common/tes_pkg.sv]
// types shared by the tx edge shaper
// assumes tes_params.svh on the include path
package tes_pkg;
  `include "tes_params.svh"

  // one rate's shaping parameters, reserved bits already stripped
  typedef struct packed {
    logic [7:0] res;
    logic [3:0] type_f;
    logic [3:0] type_r;
    logic [2:0] style_f;
    logic [2:0] style_r;
    logic scale;
    logic [4:0] count;
  } tes_cfg_t;

  typedef enum logic [1:0] {
    TES_IDLE = 2'b00,
    TES_FALL = 2'b01,
    TES_MOD = 2'b10,
    TES_RISE = 2'b11
  } tes_state_t;
endpackage

// [rtl/tes_shaper.sv]
// tx modulation edge shaper for the 212 and 424 kbit/s rates, with apb registers
// assumes carrier_tick is a one-cycle pulse per rf carrier cycle made on pclk;
// tx_modulate and power_amp_supply come from pins and are synchronised here
`timescale 1ns/1ps

// Function
// R1: the length scaling bit makes every transition state last one carrier cycle when 0 and two when 1.
// R2: the five-bit count is the number of transition states used for both falling and rising edges.
// R3: the residual amplitude sets the carrier level while modulating, zero meaning none and all ones full.
// R4: edge codes one to three give one, two or three linear transitions between levels.
// R5: edge codes four to six use a lookup table, without supply adaptation, with corrected or uncorrected adaptation.
// R6: the upper nibble of the edge type shapes the falling edge and the lower the rising edge, other codes reserved.
// R7: under linear shaping the falling style field is the falling edge time constant.
// R8: under linear shaping the rising style field is the rising edge time constant.
// R9: under table shaping each style field picks one of four tables for its edge.
// R10: what a style field means follows the edge type code of the same rate.
// R11: software writes zero to reserved bits and no reserved codes, and the shaper ignores reserved bits.
module tes_shaper
  import tes_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modulation and supply
  input wire logic carrier_tick,
  input wire logic tx_modulate,
  input wire logic [7:0] power_amp_supply,
  // to the transmitter
  output logic [7:0] tx_amplitude,
  output logic edge_active
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] residual_amplitude_rate212;
  logic [7:0] edge_type_rate212;
  logic [7:0] edge_style_rate212;
  logic [7:0] edge_length_rate212;
  logic [7:0] residual_amplitude_rate424;
  logic [7:0] edge_type_rate424;
  logic [7:0] edge_style_rate424;
  logic [7:0] edge_length_rate424;
  logic [7:0] ctrl;
  logic [7:0] lut [0:127];
  logic [9:0] idx;
  logic setup;
  logic wr_en;
  logic lut_hit;
  logic [31:0] next_rdata;
  logic next_err;

  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign lut_hit = (idx[9:7] == `TES_LUT_REGION);
  // writes land at the end of the access phase, pready is high there
  assign wr_en = clk_en & psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      residual_amplitude_rate212 <= `TES_RST_RES;
      edge_type_rate212 <= `TES_RST_TYPE;
      edge_style_rate212 <= `TES_RST_STYLE;
      edge_length_rate212 <= `TES_RST_LEN;
      residual_amplitude_rate424 <= `TES_RST_RES;
      edge_type_rate424 <= `TES_RST_TYPE;
      edge_style_rate424 <= `TES_RST_STYLE;
      edge_length_rate424 <= `TES_RST_LEN;
      ctrl <= `TES_RST_CTRL;
    end
    else if (wr_en)
    begin
      // reserved bits are dropped on the way in
      case (idx)
        `TES_IDX_RES212: residual_amplitude_rate212 <= pwdata[7:0];
        `TES_IDX_TYPE212: edge_type_rate212 <= pwdata[7:0];
        `TES_IDX_STYLE212: edge_style_rate212 <= pwdata[7:0] & `TES_STYLE_MASK; // R11
        `TES_IDX_LEN212: edge_length_rate212 <= pwdata[7:0] & `TES_LEN_MASK; // R11
        `TES_IDX_RES424: residual_amplitude_rate424 <= pwdata[7:0];
        `TES_IDX_TYPE424: edge_type_rate424 <= pwdata[7:0];
        `TES_IDX_STYLE424: edge_style_rate424 <= pwdata[7:0] & `TES_STYLE_MASK; // R11
        `TES_IDX_LEN424: edge_length_rate424 <= pwdata[7:0] & `TES_LEN_MASK; // R11
        `TES_IDX_CTRL: ctrl <= pwdata[7:0] & `TES_CTRL_MASK;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // shaping tables, reset to a plain ramp of eight per state
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++)
    begin : g_lut
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          lut[gi] <= 8'(gi * 8);
        else if (wr_en && lut_hit && idx[6:0] == 7'(gi))
          lut[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // apb answer: decoded in setup, so pready rises with the access phase
  // ------------------------------------------------------------------
  tes_state_t state;
  logic [4:0] k;
  logic dwell;

  always_comb
  begin
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (lut_hit)
      next_rdata[7:0] = lut[idx[6:0]];
    else
    begin
      case (idx)
        `TES_IDX_RES212: next_rdata[7:0] = residual_amplitude_rate212;
        `TES_IDX_TYPE212: next_rdata[7:0] = edge_type_rate212;
        `TES_IDX_STYLE212: next_rdata[7:0] = edge_style_rate212;
        `TES_IDX_LEN212: next_rdata[7:0] = edge_length_rate212;
        `TES_IDX_RES424: next_rdata[7:0] = residual_amplitude_rate424;
        `TES_IDX_TYPE424: next_rdata[7:0] = edge_type_rate424;
        `TES_IDX_STYLE424: next_rdata[7:0] = edge_style_rate424;
        `TES_IDX_LEN424: next_rdata[7:0] = edge_length_rate424;
        `TES_IDX_CTRL: next_rdata[7:0] = ctrl;
        `TES_IDX_STAT: next_rdata[15:0] = {tx_amplitude, k, state, edge_active};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready <= setup;
      pslverr <= setup & next_err;
      if (setup && !pwrite)
        prdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic mod_m;
  logic mod_s;
  logic [7:0] sup_m;
  logic [7:0] sup_s;

  // supply code is a slowly moving level; a torn sample can mix old and new bits for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mod_m <= 1'b0;
      mod_s <= 1'b0;
      sup_m <= 8'h00;
      sup_s <= 8'h00;
    end
    else if (clk_en)
    begin
      mod_m <= tx_modulate;
      mod_s <= mod_m;
      sup_m <= power_amp_supply;
      sup_s <= sup_m;
    end
  end

  // ------------------------------------------------------------------
  // edge profile
  // ------------------------------------------------------------------
  tes_cfg_t sel_cfg;
  tes_cfg_t cfg;
  logic [3:0] cur_type;
  logic [2:0] cur_style;
  logic [8:0] frac;
  logic [8:0] shaped;
  logic [7:0] next_amp;
  logic fall_ok;
  logic rise_ok;
  logic last;
  logic [15:0] d;

  function automatic logic [8:0] knee(input logic [8:0] f, input logic [2:0] tc);
    logic [8:0] kh;
    logic [17:0] p;
    kh = 9'(({6'b0, tc} + 9'h001) * `TES_KNEE_STEP);
    if (f < `TES_FRAC_HALF)
      p = ({9'b0, f} * {9'b0, kh}) >> 7;
    else
      p = {9'b0, kh} + (({9'b0, f - `TES_FRAC_HALF} * {9'b0, `TES_FRAC_ONE - kh}) >> 7);
    return p[8:0];
  endfunction

  function automatic logic valid_type(input logic [3:0] t);
    return (t >= `TES_TYPE_LIN1) && (t <= `TES_TYPE_LUT_RAW);
  endfunction

  // the style fields take their meaning from the same rate's type register
  always_comb
  begin
    sel_cfg.res = ctrl[`TES_CTRL_RATE] ? residual_amplitude_rate424 : residual_amplitude_rate212;
    {sel_cfg.type_f, sel_cfg.type_r} = ctrl[`TES_CTRL_RATE] ? edge_type_rate424 : edge_type_rate212; // R6 R10
    sel_cfg.style_f = ctrl[`TES_CTRL_RATE] ? edge_style_rate424[`TES_STYLE_F] : edge_style_rate212[`TES_STYLE_F]; // R10
    sel_cfg.style_r = ctrl[`TES_CTRL_RATE] ? edge_style_rate424[`TES_STYLE_R] : edge_style_rate212[`TES_STYLE_R]; // R10
    sel_cfg.scale = ctrl[`TES_CTRL_RATE] ? edge_length_rate424[`TES_LEN_SCALE] : edge_length_rate212[`TES_LEN_SCALE];
    sel_cfg.count = ctrl[`TES_CTRL_RATE] ? edge_length_rate424[`TES_LEN_COUNT] : edge_length_rate212[`TES_LEN_COUNT]; // R2
  end

  // reserved codes or a zero count give an abrupt step
  assign fall_ok = valid_type(sel_cfg.type_f) && sel_cfg.count != 5'd0; // R6 R11
  assign rise_ok = valid_type(cfg.type_r) && cfg.count != 5'd0; // R6 R11
  assign cur_type = (state == TES_RISE) ? cfg.type_r : cfg.type_f; // R6
  assign cur_style = (state == TES_RISE) ? cfg.style_r : cfg.style_f; // R7 R8
  assign last = (k == cfg.count) && carrier_tick && (dwell == cfg.scale); // R1 R2

  always_comb
  begin
    logic [12:0] q;
    logic [16:0] sc;
    q = 13'({k, 8'h00} / {8'h00, cfg.count}); // R2
    frac = q[8:0];
    sc = 17'b0;
    shaped = frac;
    case (cur_type)
      `TES_TYPE_LIN1: shaped = frac; // R4
      `TES_TYPE_LIN2: shaped = knee(frac, cur_style); // R4 R7 R8
      `TES_TYPE_LIN3: shaped = knee(knee(frac, cur_style), cur_style); // R4 R7 R8
      `TES_TYPE_LUT_FIX: shaped = (k == cfg.count) ? `TES_FRAC_ONE : {1'b0, lut[{cur_style[1:0], k}]}; // R5 R9
      `TES_TYPE_LUT_CORR, `TES_TYPE_LUT_RAW:
      begin
        sc = ({9'b0, lut[{cur_style[1:0], k}]} * {9'b0, sup_s}) >> 8; // R5 R9
        shaped = sc[8:0];
        // correction lands the last state exactly on the target level
        if (cur_type == `TES_TYPE_LUT_CORR && k == cfg.count)
          shaped = `TES_FRAC_ONE; // R5
      end
      default: shaped = `TES_FRAC_ONE;
    endcase
    d = ({8'h00, `TES_FULL - cfg.res} * {7'h00, shaped}) >> 8; // R3
    if (state == TES_RISE)
      next_amp = cfg.res + d[7:0];
    else
      next_amp = `TES_FULL - d[7:0];
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= TES_IDLE;
      cfg <= '0;
      k <= 5'd0;
      dwell <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state)
        TES_IDLE:
        begin
          if (mod_s && ctrl[`TES_CTRL_EN])
          begin
            // parameters are frozen for the whole frame
            cfg <= sel_cfg;
            k <= 5'd1;
            dwell <= 1'b0;
            state <= fall_ok ? TES_FALL : TES_MOD;
          end
        end
        TES_FALL, TES_RISE:
        begin
          if (carrier_tick)
          begin
            if (dwell == cfg.scale) // R1
            begin
              dwell <= 1'b0;
              k <= k + 5'd1;
            end
            else
              dwell <= 1'b1; // R1
          end
          if (last)
            state <= (state == TES_FALL) ? TES_MOD : TES_IDLE; // R2
        end
        TES_MOD:
        begin
          if (!mod_s)
          begin
            k <= 5'd1;
            dwell <= 1'b0;
            state <= rise_ok ? TES_RISE : TES_IDLE;
          end
        end
        default: state <= TES_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_amplitude <= `TES_FULL;
      edge_active <= 1'b0;
    end
    else if (clk_en)
    begin
      edge_active <= (state == TES_FALL || state == TES_RISE) && !last;
      case (state)
        TES_FALL, TES_RISE: tx_amplitude <= next_amp;
        TES_MOD: tx_amplitude <= cfg.res; // R3
        default: tx_amplitude <= `TES_FULL;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_dwell_one: assert property (@(posedge pclk) disable iff (!presetn) // R1
    clk_en && state == TES_FALL && !cfg.scale && carrier_tick && k < cfg.count |=> k == $past(k) + 5'd1)
    else $error("single-cycle state did not advance");

  a_dwell_two: assert property (@(posedge pclk) disable iff (!presetn) // R1
    clk_en && state inside {TES_FALL, TES_RISE} && cfg.scale && carrier_tick && !dwell |=> k == $past(k))
    else $error("scaled state advanced after one carrier cycle");

  a_count_end: assert property (@(posedge pclk) disable iff (!presetn) // R2
    clk_en && state == TES_FALL && last |=> state == TES_MOD)
    else $error("falling edge did not end after the programmed count");

  a_res_level: assert property (@(posedge pclk) disable iff (!presetn) // R3
    state == TES_MOD && clk_en ##1 state == TES_MOD |-> tx_amplitude == cfg.res)
    else $error("modulated level differs from residual amplitude");

  a_idle_full: assert property (@(posedge pclk) disable iff (!presetn) // R3
    state == TES_IDLE && clk_en ##1 state == TES_IDLE |-> tx_amplitude == `TES_FULL)
    else $error("carrier not full outside modulation");

  a_fw_final: assert property (@(posedge pclk) disable iff (!presetn) // R4
    clk_en && state == TES_FALL && cfg.type_f inside {[`TES_TYPE_LIN1:`TES_TYPE_LIN3]} && k == cfg.count
    |=> tx_amplitude == cfg.res)
    else $error("linear falling edge missed the residual level");

  a_corr_snap: assert property (@(posedge pclk) disable iff (!presetn) // R5
    clk_en && state == TES_RISE && cfg.type_r == `TES_TYPE_LUT_CORR && k == cfg.count |=> tx_amplitude == `TES_FULL)
    else $error("corrected table edge missed full carrier");

  a_reserved_abrupt: assert property (@(posedge pclk) disable iff (!presetn) // R6
    clk_en && state == TES_IDLE && mod_s && ctrl[`TES_CTRL_EN] && !valid_type(sel_cfg.type_f) |=> state == TES_MOD)
    else $error("reserved falling code did not step straight to modulation");

endmodule

// [test/tes_tx_stage.sv]
// transmitter stage model: makes the carrier tick that paces the shaper
// assumes the shaper's pclk domain; the carrier ticks only while run is high
`timescale 1ns/1ps
module tes_tx_stage #(
  parameter int TICK_DIV = 4
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // carrier control
  input wire logic run,
  output logic carrier_tick
);
  logic [7:0] div;

  // the carrier stands still outside frames, so no tick is ever free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div <= 8'h00;
      carrier_tick <= 1'b0;
    end
    else
    begin
      div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
      carrier_tick <= run && (div == 8'h00);
    end
  end
endmodule

// [test/tes_shaper_tb.sv]
// self-checking bench of the tx edge shaper: registers over apb, shaped frames at both rates
// assumes the transmitter stage model in tes_tx_stage.sv
`timescale 1ns/1ps
`include "tes_params.svh"
module tes_shaper_tb;
  import tes_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic carrier_tick;
  logic tx_modulate = 1'b0;
  logic [7:0] supply = 8'h80;
  logic run = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] tx_amplitude;
  logic edge_active;
  int fail_count = 0;
  int samples_checked = 0;
  int nticks = 0;
  logic [31:0] rd;
  logic err;

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (carrier_tick === 1'b1 && edge_active === 1'b1) nticks++;

  tes_shaper tes_shaper_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrier_tick(carrier_tick), .tx_modulate(tx_modulate), .power_amp_supply(supply),
    .tx_amplitude(tx_amplitude), .edge_active(edge_active));
  tes_tx_stage tes_tx_stage_i (.pclk(pclk), .presetn(presetn), .run(run), .carrier_tick(carrier_tick));

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic end_of_test;
  begin
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // upper data bits always go out as zero
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // ticks are only let run once the edge shows, so every counted tick belongs to it
  task automatic edge_run(input logic m, input logic [7:0] tgt, input int exp);
    int n;
    int t0;
    logic saw;
    logic bad;
    logic [7:0] prev;
  begin
    t0 = nticks;
    saw = 1'b0;
    bad = 1'b0;
    prev = tx_amplitude;
    n = 0;
    tx_modulate <= m;
    do
    begin
      @(posedge pclk);
      n++;
      if (edge_active === 1'b1)
      begin
        saw = 1'b1;
        run <= 1'b1;
        // a shaped edge only ever moves toward its target level
        if (m ? (tx_amplitude > prev || tx_amplitude < tgt) : (tx_amplitude < prev || tx_amplitude > tgt))
          bad = 1'b1;
      end
      prev = tx_amplitude;
    end
    while (n < 2000 && !(tx_amplitude === tgt && edge_active === 1'b0 && (saw || exp == 0)));
    run <= 1'b0;
    chk(nticks - t0, exp);
    chk(bad, 1'b0);
    chk(saw, exp != 0);
    chk({edge_active, tx_amplitude}, {1'b0, tgt});
    repeat (8) @(posedge pclk);
    chk(tx_amplitude, tgt);
  end
  endtask

  task automatic frame(input logic rate, input logic [7:0] res, ty, st, ln, input int efall, erise);
    logic [9:0] b;
  begin
    b = rate ? `TES_IDX_RES424 : `TES_IDX_RES212;
    apb(1'b1, b, res);
    apb(1'b1, b + 10'h1, ty);
    apb(1'b1, b + 10'h2, st);
    apb(1'b1, b + 10'h3, ln);
    apb(1'b1, `TES_IDX_CTRL, {6'h0, 1'b1, rate});
    edge_run(1'b1, res, efall);
    edge_run(1'b0, 8'hff, erise);
  end
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
  begin
    apb(1'b0, `TES_IDX_TYPE212, 8'h00);
    chk(rd, 32'h11);
    apb(1'b0, `TES_IDX_LEN424, 8'h00);
    chk(rd, 32'h00);
    apb(1'b0, `TES_IDX_CTRL, 8'h00);
    chk(rd, 32'h02);
    apb(1'b1, `TES_IDX_STYLE212, 8'hff);
    apb(1'b0, `TES_IDX_STYLE212, 8'h00);
    chk(rd, 32'h77);
    apb(1'b1, `TES_IDX_LEN212, 8'hff);
    apb(1'b0, `TES_IDX_LEN212, 8'h00);
    chk(rd, 32'h9f);
    apb(1'b1, 10'h3ff, 8'h5a);
    chk(err, 1'b1);
    apb(1'b0, 10'h3ff, 8'h00);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 10'h0a5, 8'ha5);
    apb(1'b0, 10'h0a5, 8'h00);
    chk({err, rd}, {1'b0, 32'ha5});
    apb(1'b0, `TES_IDX_STAT, 8'h00);
    chk(rd, 32'hff00);
    $display("test regs done");
  end
  endtask

  task automatic t_length;
  begin
    frame(1'b0, 8'h40, 8'h11, 8'h00, 8'h05, 5, 5);
    frame(1'b0, 8'h40, 8'h11, 8'h00, 8'h85, 10, 10);
    frame(1'b0, 8'hfe, 8'h11, 8'h00, 8'h81, 2, 2);
    frame(1'b0, 8'h00, 8'h11, 8'h00, 8'h1f, 31, 31);
    $display("test length done");
  end
  endtask

  // codes one to six in both nibbles, every style value; the 212 set keeps count 31 meanwhile
  task automatic t_codes;
    logic [3:0] c;
    logic [2:0] s;
  begin
    for (int ci = 1; ci <= 6; ci++)
    begin
      for (int si = 0; si < 8; si++)
      begin
        c = 4'(ci);
        s = 3'(si);
        frame(1'b1, 8'(ci * 32 + si), {c, c}, {1'b0, s, 1'b0, ~s}, 8'h03, 3, 3);
      end
    end
    $display("test codes done");
  end
  endtask

  task automatic t_reserved;
  begin
    frame(1'b1, 8'h33, 8'h77, 8'h00, 8'h04, 0, 0);
    frame(1'b1, 8'h33, 8'h10, 8'h00, 8'h04, 4, 0);
    frame(1'b1, 8'h33, 8'h05, 8'h12, 8'h04, 0, 4);
    frame(1'b0, 8'h55, 8'h11, 8'h00, 8'h00, 0, 0);
    $display("test reserved done");
  end
  endtask

  // with the enable low a raised modulate request must not reach the sequencer
  task automatic t_freeze;
  begin
    @(posedge pclk);
    clk_en <= 1'b0;
    tx_modulate <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({edge_active, tx_amplitude}, 9'h0ff);
    tx_modulate <= 1'b0;
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(tx_amplitude, 8'hff);
    $display("test freeze done");
  end
  endtask

  // --------------------------------------------------------------------
  // sequence and watchdog
  // --------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_length();
    t_codes();
    t_reserved();
    t_freeze();
    end_of_test();
  end

  initial
  begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
